// File: logic/wmca_timing_regs.vh
// Constants for the channel-access timing block
`ifndef WMCA_TIMING_REGS_VH
`define WMCA_TIMING_REGS_VH
// Clock period and microsecond in nanoseconds
`define WMCA_CLK_PERIOD_NS 10
`define WMCA_US_NS 1000
// Cycles per microsecond tick, derived from the two figures above
`define WMCA_CYC_PER_US (`WMCA_US_NS / `WMCA_CLK_PERIOD_NS)
// Arbitration policies
`define WMCA_ARB_FIXED 1'b0
`define WMCA_ARB_ROUND 1'b1
// Reset values
`define WMCA_NAV_RESET 16'h0000
`define WMCA_TSF_RESET 64'h0000000000000000
`define WMCA_TBTT_RESET 64'h0000000000000000
`endif

// File: logic/wmca_backoff.v
// Backoff counter for one access category
`timescale 1ns/1ps
`default_nettype none
module wmca_backoff #(
    parameter CW = 10
) (
    input wire clock,
    input wire rst,
    input wire clk_en,
    input wire load,
    input wire [CW-1:0] load_val,
    input wire slot_end,
    input wire grant,
    output reg [CW-1:0] count_reg,
    output reg pending_reg
);
    // Count down once per idle slot; flag pending at zero until granted
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= {CW{1'b0}};
            pending_reg <= 1'b0;
        end else if (clk_en) begin
            if (load) begin
                count_reg <= load_val;
                pending_reg <= (load_val == {CW{1'b0}});
            end else if (slot_end && count_reg != {CW{1'b0}}) begin
                count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
                if (count_reg == {{(CW-1){1'b0}}, 1'b1})
                    pending_reg <= 1'b1;
            end else if (grant) begin
                pending_reg <= 1'b0;
            end
        end
    end
endmodule // wmca_backoff
`default_nettype wire

// File: logic/wmca_timing.v
// Channel-access timing: spacing timers, backoff, NAV, TSF, sleep timer
`timescale 1ns/1ps
`default_nettype none
`include "wmca_timing_regs.vh"
module wmca_timing #(
    parameter NUM_AC = 4,
    parameter CW = 10,
    parameter TW = 16
) (
    input wire clock,
    input wire rst,
    input wire clk_en,
    input wire phy_cca_busy,
    input wire slow_clk,
    input wire [TW-1:0] sifs_cycles,
    input wire [TW-1:0] rifs_cycles,
    input wire [TW-1:0] aifs_cycles,
    input wire [TW-1:0] slot_cycles,
    input wire arb_policy,
    input wire [NUM_AC-1:0] bo_load,
    input wire [CW-1:0] bo_load_val,
    input wire tx_frame_ready,
    input wire tx_use_rifs,
    input wire nav_load,
    input wire [15:0] nav_duration,
    input wire nav_clear,
    input wire tsf_load,
    input wire [63:0] tsf_load_val,
    input wire tsf_add,
    input wire [63:0] tsf_add_val,
    input wire tbtt_load,
    input wire [63:0] tbtt_load_val,
    input wire [31:0] bcn_interval,
    input wire [1:0] evt_arm,
    input wire [31:0] evt_offset,
    input wire sleep_load,
    input wire [31:0] sleep_ticks,
    output wire medium_busy,
    output reg sifs_trig_reg,
    output reg rifs_trig_reg,
    output reg tx_start_reg,
    output reg [NUM_AC-1:0] ac_grant_reg,
    output wire [NUM_AC-1:0] ac_pending,
    output reg [15:0] nav_reg,
    output reg [63:0] tsf_reg,
    output reg [63:0] tbtt_reg,
    output reg tbtt_pulse_reg,
    output reg [1:0] evt_pulse_reg,
    output reg sleep_active_reg,
    output reg wake_pulse_reg
);
    // ****************************************************************
    // Functions
    // ****************************************************************

    // Pick one pending category: fixed favours the highest index,
    // round robin starts just above the last winner
    function [NUM_AC-1:0] arbitrate;
        input [NUM_AC-1:0] req;
        input policy;
        input [NUM_AC-1:0] last;
        integer i;
        integer start;
        integer idx;
        reg found;
        begin
            arbitrate = {NUM_AC{1'b0}};
            found = 1'b0;
            start = 0;
            idx = 0;
            if (policy == `WMCA_ARB_ROUND) begin
                for (i = 0; i < NUM_AC; i = i + 1) begin
                    if (last[i])
                        start = i + 1;
                end
                for (i = 0; i < NUM_AC; i = i + 1) begin
                    idx = (start + i) % NUM_AC;
                    if (!found && req[idx]) begin
                        arbitrate[idx] = 1'b1;
                        found = 1'b1;
                    end
                end
            end else begin
                for (i = NUM_AC - 1; i >= 0; i = i - 1) begin
                    if (!found && req[i]) begin
                        arbitrate[i] = 1'b1;
                        found = 1'b1;
                    end
                end
            end
        end
    endfunction

    // Saturating increment of a spacing counter
    function [TW-1:0] sat_inc;
        input [TW-1:0] v;
        begin
            if (v == {TW{1'b1}})
                sat_inc = v;
            else
                sat_inc = v + {{(TW-1){1'b0}}, 1'b1};
        end
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************

    reg cca_meta_reg;
    reg cca_sync_reg;
    reg slow_meta_reg;
    reg slow_sync_reg;
    reg slow_prev_reg;

    // Two flops on the CCA and slow clock pins before any logic looks at them
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cca_meta_reg <= 1'b0;
            cca_sync_reg <= 1'b0;
            slow_meta_reg <= 1'b0;
            slow_sync_reg <= 1'b0;
            slow_prev_reg <= 1'b0;
        end else if (clk_en) begin
            cca_meta_reg <= phy_cca_busy;
            cca_sync_reg <= cca_meta_reg;
            slow_meta_reg <= slow_clk;
            slow_sync_reg <= slow_meta_reg;
            slow_prev_reg <= slow_sync_reg;
        end
    end

    wire slow_rise = slow_sync_reg & ~slow_prev_reg;

    // ****************************************************************
    // Microsecond tick
    // ****************************************************************

    localparam integer US_LAST_INT = `WMCA_CYC_PER_US - 1;
    localparam [6:0] US_LAST = US_LAST_INT[6:0];
    reg [6:0] us_div_reg;
    wire us_tick = (us_div_reg == US_LAST);

    // Divides the MAC clock down to the NAV and TSF time base
    always @(posedge clock or posedge rst) begin
        if (rst)
            us_div_reg <= 7'h00;
        else if (clk_en)
            us_div_reg <= us_tick ? 7'h00 : us_div_reg + 7'h01;
    end

    // ****************************************************************
    // NAV timer
    // ****************************************************************

    // Load keeps the longer reservation; counts down in microseconds
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            nav_reg <= `WMCA_NAV_RESET;
        end else if (clk_en) begin
            if (nav_clear)
                nav_reg <= 16'h0000;
            else if (nav_load && nav_duration > nav_reg)
                nav_reg <= nav_duration;
            else if (us_tick && nav_reg != 16'h0000)
                nav_reg <= nav_reg - 16'h0001;
        end
    end

    // Physical and virtual carrier sense together
    assign medium_busy = cca_sync_reg | (nav_reg != 16'h0000);

    // ****************************************************************
    // Interframe spacing timers and slot clock
    // ****************************************************************

    reg [TW-1:0] idle_cnt_reg;
    reg [TW-1:0] slot_cnt_reg;
    reg in_slots_reg;
    wire slot_end = in_slots_reg && !medium_busy &&
                    (slot_cnt_reg == slot_cycles - {{(TW-1){1'b0}}, 1'b1});

    // Idle time restarts at each busy cycle, so a busy slot never ends
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            idle_cnt_reg <= {TW{1'b0}};
            slot_cnt_reg <= {TW{1'b0}};
            in_slots_reg <= 1'b0;
        end else if (clk_en) begin
            if (medium_busy) begin
                idle_cnt_reg <= {TW{1'b0}};
                slot_cnt_reg <= {TW{1'b0}};
                in_slots_reg <= 1'b0;
            end else begin
                idle_cnt_reg <= sat_inc(idle_cnt_reg);
                if (!in_slots_reg) begin
                    in_slots_reg <= (sat_inc(idle_cnt_reg) == aifs_cycles);
                end else if (slot_end) begin
                    slot_cnt_reg <= {TW{1'b0}};
                end else begin
                    slot_cnt_reg <= sat_inc(slot_cnt_reg);
                end
            end
        end
    end

    wire sifs_hit = !medium_busy &&
                    (sat_inc(idle_cnt_reg) == sifs_cycles);
    wire rifs_hit = !medium_busy &&
                    (sat_inc(idle_cnt_reg) == rifs_cycles);

    // One-cycle start instants after the programmed idle time
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sifs_trig_reg <= 1'b0;
            rifs_trig_reg <= 1'b0;
            tx_start_reg <= 1'b0;
        end else if (clk_en) begin
            sifs_trig_reg <= sifs_hit;
            rifs_trig_reg <= rifs_hit;
            tx_start_reg <= tx_frame_ready &&
                            (tx_use_rifs ? rifs_hit : sifs_hit);
        end else begin
            sifs_trig_reg <= 1'b0;
            rifs_trig_reg <= 1'b0;
            tx_start_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Backoff engines and grant
    // ****************************************************************

    wire [NUM_AC-1:0] grant_now;
    reg [NUM_AC-1:0] last_grant_reg;
    wire [CW-1:0] bo_count [0:NUM_AC-1];

    genvar g;
    generate
        for (g = 0; g < NUM_AC; g = g + 1) begin : ac
            // Each category counts its own idle slots
            wmca_backoff #(
                .CW(CW)
            ) u_bo (
                .clock(clock),
                .rst(rst),
                .clk_en(clk_en),
                .load(bo_load[g]),
                .load_val(bo_load_val),
                .slot_end(slot_end),
                .grant(grant_now[g]),
                .count_reg(bo_count[g]),
                .pending_reg(ac_pending[g])
            );
        end
    endgenerate

    // At most one category wins per cycle, and none while the medium is busy
    assign grant_now = medium_busy ? {NUM_AC{1'b0}} :
        arbitrate(ac_pending, arb_policy, last_grant_reg);

    // Grant pulse to the transmit engine, remembered for round robin
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ac_grant_reg <= {NUM_AC{1'b0}};
            last_grant_reg <= {NUM_AC{1'b0}};
        end else if (clk_en) begin
            ac_grant_reg <= grant_now;
            if (grant_now != {NUM_AC{1'b0}})
                last_grant_reg <= grant_now;
        end else begin
            ac_grant_reg <= {NUM_AC{1'b0}};
        end
    end

    // ****************************************************************
    // TSF timer, beacon time and event triggers
    // ****************************************************************

    reg [31:0] evt_time_reg [0:1];
    reg [1:0] evt_armed_reg;
    wire [63:0] tsf_step = us_tick ? 64'h0000000000000001 : 64'h0;
    integer e;

    // Load wins over an adjust, which is added on top of the plain tick
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tsf_reg <= `WMCA_TSF_RESET;
        end else if (clk_en) begin
            if (tsf_load)
                tsf_reg <= tsf_load_val;
            else if (tsf_add)
                tsf_reg <= tsf_reg + tsf_add_val + tsf_step;
            else
                tsf_reg <= tsf_reg + tsf_step;
        end
    end

    // Beacon time advances by one interval each time it is reached
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tbtt_reg <= `WMCA_TBTT_RESET;
            tbtt_pulse_reg <= 1'b0;
        end else if (clk_en) begin
            tbtt_pulse_reg <= 1'b0;
            if (tbtt_load) begin
                tbtt_reg <= tbtt_load_val;
            end else if (us_tick && tsf_reg == tbtt_reg) begin
                tbtt_pulse_reg <= 1'b1;
                tbtt_reg <= tbtt_reg + {32'h00000000, bcn_interval};
            end
        end else begin
            tbtt_pulse_reg <= 1'b0;
        end
    end

    // Events fire once when the low TSF word meets the armed time
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            evt_armed_reg <= 2'b00;
            evt_pulse_reg <= 2'b00;
            evt_time_reg[0] <= 32'h00000000;
            evt_time_reg[1] <= 32'h00000000;
        end else if (clk_en) begin
            for (e = 0; e < 2; e = e + 1) begin
                evt_pulse_reg[e] <= 1'b0;
                if (evt_arm[e]) begin
                    evt_time_reg[e] <= tsf_reg[31:0] + evt_offset;
                    evt_armed_reg[e] <= 1'b1;
                end else if (evt_armed_reg[e] && us_tick &&
                             tsf_reg[31:0] == evt_time_reg[e]) begin
                    evt_pulse_reg[e] <= 1'b1;
                    evt_armed_reg[e] <= 1'b0;
                end
            end
        end else begin
            evt_pulse_reg <= 2'b00;
        end
    end

    // ****************************************************************
    // Power-save sleep timer
    // ****************************************************************

    reg [31:0] sleep_cnt_reg;

    // Counts slow-clock edges; expiry asks for the MAC clock back
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sleep_cnt_reg <= 32'h00000000;
            sleep_active_reg <= 1'b0;
            wake_pulse_reg <= 1'b0;
        end else if (clk_en) begin
            wake_pulse_reg <= 1'b0;
            if (sleep_load) begin
                sleep_cnt_reg <= sleep_ticks;
                sleep_active_reg <= (sleep_ticks != 32'h00000000);
                wake_pulse_reg <= (sleep_ticks == 32'h00000000);
            end else if (sleep_active_reg && slow_rise) begin
                sleep_cnt_reg <= sleep_cnt_reg - 32'h00000001;
                if (sleep_cnt_reg == 32'h00000001) begin
                    sleep_active_reg <= 1'b0;
                    wake_pulse_reg <= 1'b1;
                end
            end
        end else begin
            wake_pulse_reg <= 1'b0;
        end
    end
endmodule // wmca_timing
`default_nettype wire

// File: bench/wmca_timing_assertions.sv
// Checker of the channel-access timing relations at the top ports
`timescale 1ns/1ps
`default_nettype none
module wmca_timing_chk #(
    parameter NUM_AC = 4,
    parameter TW = 16
) (
    input wire clock,
    input wire rst,
    input wire clk_en,
    input wire [TW-1:0] sifs_cycles,
    input wire [TW-1:0] rifs_cycles,
    input wire arb_policy,
    input wire tx_frame_ready,
    input wire tx_use_rifs,
    input wire nav_load,
    input wire [15:0] nav_duration,
    input wire nav_clear,
    input wire tsf_add,
    input wire [63:0] tsf_add_val,
    input wire tsf_load,
    input wire [31:0] bcn_interval,
    input wire medium_busy,
    input wire sifs_trig_reg,
    input wire rifs_trig_reg,
    input wire tx_start_reg,
    input wire [NUM_AC-1:0] ac_grant_reg,
    input wire [NUM_AC-1:0] ac_pending,
    input wire [15:0] nav_reg,
    input wire [63:0] tsf_reg,
    input wire [63:0] tbtt_reg,
    input wire tbtt_pulse_reg,
    input wire sleep_active_reg,
    input wire wake_pulse_reg
);
    // ***************************************
    // Idle-cycle count and timing properties
    // ***************************************
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [TW-1:0] idle_reg;
    // Consecutive idle cycles seen so far, cleared by any busy cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idle_reg <= {TW{1'b0}};
        end else if (clk_en) begin
            idle_reg <= medium_busy ? {TW{1'b0}} : idle_reg + 1'b1;
        end
    end
    property p_sifs;
        sifs_trig_reg |-> idle_reg == sifs_cycles;
    endproperty
    a_sifs: assert property (p_sifs)
        else $error("short spacing trigger at wrong idle count");
    property p_rifs;
        rifs_trig_reg |-> idle_reg == rifs_cycles;
    endproperty
    a_rifs: assert property (p_rifs)
        else $error("reduced spacing trigger at wrong idle count");
    property p_txs;
        tx_start_reg |-> $past(tx_frame_ready)
            && ($past(tx_use_rifs) ? rifs_trig_reg : sifs_trig_reg);
    endproperty
    a_txs: assert property (p_txs)
        else $error("transmit start without its spacing trigger");
    property p_vcs;
        nav_reg != 16'h0000 |-> medium_busy ##1
            (!sifs_trig_reg && !rifs_trig_reg && ac_grant_reg == '0);
    endproperty
    a_vcs: assert property (p_vcs)
        else $error("medium idle while NAV runs");
    property p_grant;
        |ac_grant_reg |-> $onehot(ac_grant_reg) && !$past(medium_busy)
            && (ac_grant_reg & $past(ac_pending)) == ac_grant_reg;
    endproperty
    a_grant: assert property (p_grant)
        else $error("grant not one pending category on idle medium");
    property p_fix;
        |ac_grant_reg && !$past(arb_policy)
            |-> ($past(ac_pending) & ~ac_grant_reg) < ac_grant_reg;
    endproperty
    a_fix: assert property (p_fix)
        else $error("fixed policy did not grant highest category");
    property p_nav;
        $past(nav_load) && !$past(nav_clear)
            && $past(nav_duration) > $past(nav_reg)
            |-> nav_reg == $past(nav_duration);
    endproperty
    a_nav: assert property (p_nav)
        else $error("longer duration not taken into NAV");
    property p_tsfa;
        $past(tsf_add) && !$past(tsf_load)
            |-> tsf_reg - $past(tsf_reg) - $past(tsf_add_val) <= 64'h1;
    endproperty
    a_tsfa: assert property (p_tsfa)
        else $error("TSF advance by sleep time wrong");
    property p_tbtt;
        tbtt_pulse_reg |-> $past(tsf_reg) == $past(tbtt_reg)
            && tbtt_reg == $past(tbtt_reg) + 64'($past(bcn_interval));
    endproperty
    a_tbtt: assert property (p_tbtt)
        else $error("beacon time pulse or update wrong");
    property p_wake;
        $fell(sleep_active_reg) |-> wake_pulse_reg;
    endproperty
    a_wake: assert property (p_wake)
        else $error("sleep ended without wake pulse");
endmodule // wmca_timing_chk
bind wmca_timing wmca_timing_chk #(.NUM_AC(NUM_AC), .TW(TW)) wmca_chk_inst (
    .clock, .rst, .clk_en, .sifs_cycles, .rifs_cycles, .arb_policy,
    .tx_frame_ready, .tx_use_rifs, .nav_load, .nav_duration, .nav_clear,
    .tsf_add, .tsf_add_val, .tsf_load, .bcn_interval, .medium_busy,
    .sifs_trig_reg, .rifs_trig_reg, .tx_start_reg, .ac_grant_reg,
    .ac_pending, .nav_reg, .tsf_reg, .tbtt_reg, .tbtt_pulse_reg,
    .sleep_active_reg, .wake_pulse_reg
);
`default_nettype wire

// File: bench/wmca_seq_model.sv
// Model of the sequencer and transmit engine beside the timing block
`timescale 1ns/1ps
`default_nettype none
module wmca_seq_model (
    input wire clock,
    input wire rst,
    input wire medium_busy,
    input wire tx_start_reg,
    input wire sleep_active_reg,
    input wire wake_pulse_reg,
    output logic tx_frame_ready,
    output logic tx_use_rifs,
    output logic tsf_add,
    output logic [63:0] tsf_add_val,
    output logic [31:0] tx_count
);
    // ****************
    // Sequencer model
    // ****************
    logic [31:0] slp_cyc;
    // Schedules a frame while busy, counts sends, repairs TSF after sleep
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            {tx_frame_ready, tx_use_rifs, tsf_add, tsf_add_val} <= '0;
            {tx_count, slp_cyc} <= '0;
        end else begin
            tsf_add <= 1'b0;
            if (medium_busy) begin
                tx_frame_ready <= 1'b1;
            end
            if (tx_start_reg) begin
                tx_frame_ready <= 1'b0;
                tx_use_rifs <= ~tx_use_rifs;
                tx_count <= tx_count + 32'h1;
            end
            slp_cyc <= sleep_active_reg ? slp_cyc + 32'h1 : 32'h0;
            if (wake_pulse_reg) begin
                tsf_add <= 1'b1;
                tsf_add_val <= {32'h0, slp_cyc / 32'h64};
            end
        end
    end
endmodule // wmca_seq_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the channel-access timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ***********************
    // Signals and instances
    // ***********************
    logic clock, rst, clk_en, phy_cca_busy, slow_clk, arb_policy;
    logic [15:0] sifs_cycles, rifs_cycles, aifs_cycles, slot_cycles;
    logic [3:0] bo_load, ac_grant_reg, ac_pending;
    logic [9:0] bo_load_val;
    logic tx_frame_ready, tx_use_rifs, nav_load, nav_clear, tsf_load;
    logic tsf_add, tbtt_load, sleep_load, medium_busy, sifs_trig_reg;
    logic rifs_trig_reg, tx_start_reg, tbtt_pulse_reg, sleep_active_reg;
    logic wake_pulse_reg;
    logic [15:0] nav_duration, nav_reg;
    logic [63:0] tsf_load_val, tsf_add_val, tbtt_load_val, tsf_reg, tbtt_reg;
    logic [31:0] bcn_interval, evt_offset, sleep_ticks, tx_count;
    logic [1:0] evt_arm, evt_pulse_reg, sdiv;
    logic [63:0] t0;
    logic [3:0] q[$];
    int error_cnt = 0;
    int n_compared = 0;
    int i, k, ks, kr, e, ex;
    wmca_timing wmca_timing_inst (
        .clock, .rst, .clk_en, .phy_cca_busy, .slow_clk, .sifs_cycles,
        .rifs_cycles, .aifs_cycles, .slot_cycles, .arb_policy, .bo_load,
        .bo_load_val, .tx_frame_ready, .tx_use_rifs, .nav_load,
        .nav_duration, .nav_clear, .tsf_load, .tsf_load_val, .tsf_add,
        .tsf_add_val, .tbtt_load, .tbtt_load_val, .bcn_interval, .evt_arm,
        .evt_offset, .sleep_load, .sleep_ticks, .medium_busy,
        .sifs_trig_reg, .rifs_trig_reg, .tx_start_reg, .ac_grant_reg,
        .ac_pending, .nav_reg, .tsf_reg, .tbtt_reg, .tbtt_pulse_reg,
        .evt_pulse_reg, .sleep_active_reg, .wake_pulse_reg
    );
    wmca_seq_model wmca_seq_model_inst (
        .clock, .rst, .medium_busy, .tx_start_reg, .sleep_active_reg,
        .wake_pulse_reg, .tx_frame_ready, .tx_use_rifs, .tsf_add,
        .tsf_add_val, .tx_count
    );
    // Main clock and a slow clock of eight main cycles
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        sdiv <= sdiv + 2'h1;
        if (sdiv == 2'h3) slow_clk <= ~slow_clk;
    end
    // Comparison, verdict and watchdog
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        close_out;
    end
    // Test sequence
    initial begin
        {rst, clk_en, phy_cca_busy} = 3'h7;
        {slow_clk, sdiv, arb_policy, bo_load, bo_load_val} = '0;
        {nav_load, nav_clear, tsf_load, tbtt_load, sleep_load, evt_arm} = '0;
        {nav_duration, tsf_load_val, tbtt_load_val, bcn_interval} = '0;
        {evt_offset, sleep_ticks} = '0;
        {sifs_cycles, rifs_cycles, aifs_cycles, slot_cycles} = {4{16'h4}};
        void'($urandom(65));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk(tsf_reg | tbtt_reg | nav_reg | ac_pending, 0);
        // Spacing triggers and transmit start over random idle counts
        for (i = 0; i < 4; i++) begin
            @(posedge clock);
            phy_cca_busy <= 1'b1;
            sifs_cycles <= 16'h3 + 16'($urandom % 8);
            rifs_cycles <= 16'h3 + 16'($urandom % 8);
            e = tx_count;
            repeat (4) @(posedge clock);
            phy_cca_busy <= 1'b0;
            @(negedge clock);
            while (medium_busy) @(negedge clock);
            {ks, kr} = '0;
            for (k = 0; k < 40; k++) begin
                if (sifs_trig_reg) ks = k;
                if (rifs_trig_reg) kr = k;
                @(negedge clock);
            end
            chk(ks, sifs_cycles);
            chk(kr, rifs_cycles);
            chk(tx_count, e + 1);
        end
        // Backoff paused by busy slots, then counted down
        @(posedge clock);
        phy_cca_busy <= 1'b1;
        aifs_cycles <= 16'h2 + 16'($urandom % 4);
        slot_cycles <= 16'h2 + 16'($urandom % 4);
        e = 1 + $urandom % 4;
        i = $urandom % 4;
        repeat (4) @(posedge clock);
        {bo_load, bo_load_val} <= {4'h1 << i, 10'(e)};
        @(posedge clock);
        bo_load <= 4'h0;
        repeat (60) @(posedge clock);
        phy_cca_busy <= 1'b0;
        chk(ac_pending, 0);
        ex = aifs_cycles + e * slot_cycles;
        @(negedge clock);
        while (medium_busy) @(negedge clock);
        for (k = 0; k < 80 && ac_grant_reg === 4'h0; k++) @(negedge clock);
        chk(ac_grant_reg, 4'h1 << i);
        chk(k >= ex && k <= ex + 4, 1);
        // Simultaneous zeros under both policies
        for (i = 0; i < 2; i++) begin
            @(posedge clock);
            {phy_cca_busy, arb_policy} <= {1'b1, i[0]};
            repeat (4) @(posedge clock);
            {bo_load, bo_load_val} <= {4'hF, 10'h0};
            @(posedge clock);
            bo_load <= 4'h0;
            repeat (3) @(posedge clock);
            chk(ac_pending, 4'hF);
            phy_cca_busy <= 1'b0;
            q.delete();
            for (k = 0; k < 20; k++) begin
                @(negedge clock);
                if (ac_grant_reg !== 4'h0) q.push_back(ac_grant_reg);
            end
            chk(q.size(), 4);
            e = 0;
            foreach (q[j]) begin
                e = e | q[j];
                if (i == 0) chk(q[j], 4'h8 >> j);
            end
            chk(e, 15);
        end
        // NAV keeps the longer duration and counts down in microseconds
        t0 = tsf_reg;
        while (tsf_reg == t0) @(negedge clock);
        @(posedge clock);
        {nav_load, nav_duration} <= {1'b1, 16'h3};
        @(posedge clock);
        nav_duration <= 16'h2;
        @(posedge clock);
        nav_load <= 1'b0;
        @(negedge clock);
        chk(nav_reg, 3);
        chk(medium_busy, 1);
        for (k = 0; k < 500 && nav_reg !== 16'h0; k++) @(negedge clock);
        chk(k >= 195 && k <= 300, 1);
        chk(medium_busy, 0);
        // TSF load across a word carry, beacon time and event triggers
        @(posedge clock);
        {tsf_load, tsf_load_val} <= {1'b1, 64'h0000_0000_FFFF_FFFE};
        {tbtt_load, tbtt_load_val} <= {1'b1, 64'h0000_0001_0000_0001};
        bcn_interval <= 32'h5;
        @(posedge clock);
        {tsf_load, tbtt_load, evt_arm, evt_offset} <= {4'h3, 32'h2};
        @(negedge clock);
        chk(tsf_reg - tsf_load_val <= 1, 1);
        chk(tbtt_reg, tbtt_load_val);
        t0 = tsf_reg + 2;
        @(posedge clock);
        evt_arm <= 2'h0;
        {ks, kr} = '0;
        for (k = 0; k < 600; k++) begin
            @(negedge clock);
            if (evt_pulse_reg !== 2'h0) begin
                kr++;
                chk(evt_pulse_reg, 2'h3);
                chk(tsf_reg[31:0] - t0[31:0] <= 1, 1);
            end
            if (tbtt_pulse_reg) begin
                ks++;
                chk(tbtt_reg, tbtt_load_val + 5);
            end
        end
        chk({ks, kr}, {32'h1, 32'h1});
        // Sleep timer on the slow clock, then TSF repaired by the sequencer
        @(posedge clock);
        {sleep_load, sleep_ticks} <= {1'b1, 32'h28};
        @(posedge clock);
        sleep_load <= 1'b0;
        @(negedge clock);
        chk(sleep_active_reg, 1);
        t0 = tsf_reg;
        for (k = 0; k < 600 && wake_pulse_reg !== 1'b1; k++) @(negedge clock);
        chk(sleep_active_reg, 0);
        chk(k >= 300 && k <= 335, 1);
        repeat (3) @(negedge clock);
        e = 2 * (k / 100);
        chk(tsf_reg - t0 >= e && tsf_reg - t0 <= e + 2, 1);
        // Clock enable low freezes the timers as a stopped clock would
        @(posedge clock);
        clk_en <= 1'b0;
        @(negedge clock);
        t0 = tsf_reg;
        repeat (150) @(negedge clock);
        chk(tsf_reg, t0);
        @(posedge clock);
        clk_en <= 1'b1;
        close_out;
    end
endmodule // tb
`default_nettype wire
